// file: meas_model.sv
// measurement front end and breaker circuit model for the relay bench
`timescale 1ns/1ps
module meas_model (
	input wire logic clk_i,
	input wire logic [2:0][15:0] pn_i,
	input wire logic [2:0][15:0] ll_i,
	input wire logic [15:0] f_i,
	input wire logic open_i,
	input wire logic trip_i,
	output logic [2:0][15:0] pn_o,
	output logic [2:0][15:0] ll_o,
	output logic [15:0] f_o,
	output logic brk_closed_o
);
	// rms values lag the line by one sample, as a real filter would
	// one process drives every output so each has a single driver
	initial begin
		pn_o = {3{16'h03e8}};
		ll_o = {3{16'h03e8}};
		f_o = 16'h0258;
		brk_closed_o = 1'b1;
		forever begin
			@(posedge clk_i);
			pn_o <= pn_i;
			ll_o <= ll_i;
			f_o <= f_i;
			// breaker stays open once commanded; no reclose in this model
			if (open_i || trip_i) begin
				brk_closed_o <= 1'b0;
			end
		end
	end
endmodule

// file: over_voltage_frequency_relay_tb.sv
// self-checking bench for the over voltage / frequency relay
`timescale 1ns/1ps
module over_voltage_frequency_relay_tb;
	import ovf_relay_pkg::*;
	localparam int TK = 10;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o, brk_open_o, brk_trip_o, lockout_o, alarm_o, closed;
	logic [15:0] event_o, van, vbn, vcn, vab, vbc, vca, fa;
	logic [15:0] ev_seen = 16'h0;
	logic ev_clr = 1'b0;
	logic [15:0] f_c = 16'h0258;
	logic [2:0][15:0] pn_c = {3{16'h03e8}};
	logic [2:0][15:0] ll_c = {3{16'h03e8}};
	logic hit;
	int mismatches = 0;
	int n_checks = 0;
	int cyc_n = 0;
	int n;
	ovf_relay #(.TICK_CYCLES(TK)) ovf_relay_i (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.van_i(van), .vbn_i(vbn), .vcn_i(vcn), .vab_i(vab), .vbc_i(vbc),
		.vca_i(vca), .freq_a_i(fa), .brk_open_o(brk_open_o),
		.brk_trip_o(brk_trip_o), .lockout_o(lockout_o),
		.alarm_o(alarm_o), .event_o(event_o));
	meas_model meas_model_i (.clk_i(clk_i), .pn_i(pn_c), .ll_i(ll_c),
		.f_i(f_c), .open_i(brk_open_o), .trip_i(brk_trip_o),
		.pn_o({vcn, vbn, van}), .ll_o({vca, vbc, vab}), .f_o(fa),
		.brk_closed_o(closed));
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// event pulses last one cycle, so collect them for the waits
	always @(posedge clk_i) begin
		ev_seen <= ev_clr ? 16'h0 : (ev_seen | event_o);
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hf);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
		// ends on ack; if ack never comes only the bench timeout ends this wait
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
		// let the write settle before callers look at outputs
		#1;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk("register", rd, e);
	endtask
	task automatic clr();
		@(posedge clk_i) ev_clr <= 1'b1;
		@(posedge clk_i) ev_clr <= 1'b0;
	endtask
	task automatic wait_ev(input int b, input int lim);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (ev_seen[b] !== 1'b1 && n < lim);
		hit = ev_seen[b];
	endtask
	task automatic setpn(input logic [15:0] a, b, c);
		@(posedge clk_i) pn_c <= {c, b, a};
		clr();
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rdchk(8'h00, 32'h0);
		rdchk(8'h10, 32'h00010069);
		wb(1'b1, 8'h10, 32'h000000c8);
		rdchk(8'h10, 32'h0001007d);
		wb(1'b1, 8'h0c, 32'h0000001f, 4'h2);
		rdchk(8'h0c, 32'h00000004);
		wb(1'b1, 8'h3c, 32'hffffffff);
		rdchk(8'h3c, 32'h0);
	endtask
	task automatic t_ov_trip();
		wb(1'b1, 8'h10, 32'h0002006e);
		wb(1'b1, 8'h00, 32'h00000007);
		setpn(16'h04b0, 16'h03e8, 16'h03e8);
		wait_ev(0, 10);
		chk("ov pickup", hit, 1'b1);
		wait_ev(1, 150);
		chk("ov delay", n inside {[90:111]}, 1'b1);
		chk("trip", {brk_trip_o, brk_open_o, lockout_o}, 3'b101);
		setpn(16'h042e, 16'h03e8, 16'h03e8);
		wait_ev(2, 30);
		chk("no dropout at 97%", hit, 1'b0);
		setpn(16'h0424, 16'h03e8, 16'h03e8);
		wait_ev(2, 10);
		chk("ov dropout", hit, 1'b1);
		wb(1'b1, 8'h2c, 32'h1);
		chk("lockout cleared", lockout_o, 1'b0);
		chk("breaker opened", closed, 1'b0);
		// a short pickup must not shorten the next delay
		wb(1'b1, 8'h00, 32'h00000005);
		setpn(16'h04b0, 16'h03e8, 16'h03e8);
		repeat (60) @(posedge clk_i);
		setpn(16'h0424, 16'h03e8, 16'h03e8);
		repeat (3) @(posedge clk_i);
		setpn(16'h04b0, 16'h03e8, 16'h03e8);
		wait_ev(1, 150);
		chk("restarted delay", n inside {[90:111]}, 1'b1);
		chk("open", {brk_open_o, lockout_o}, 2'b10);
		wb(1'b1, 8'h00, 32'h0);
	endtask
	task automatic t_ov_phases();
		wb(1'b1, 8'h14, 32'h0001006e);
		wb(1'b1, 8'h04, 32'h0000000d);
		setpn(16'h04b0, 16'h04b0, 16'h03e8);
		wait_ev(3, 30);
		chk("two of three", hit, 1'b0);
		wb(1'b1, 8'h20, 32'h1);
		@(posedge clk_i) ll_c <= {3{16'h04b0}};
		wait_ev(3, 10);
		chk("delta pickup", hit, 1'b1);
		wait_ev(4, 80);
		chk("alarm", {hit, alarm_o}, 2'b11);
		wb(1'b1, 8'h04, 32'h0);
		repeat (3) @(posedge clk_i);
		chk("disabled", alarm_o, 1'b0);
		wb(1'b1, 8'h20, 32'h0);
	endtask
	task automatic t_of();
		setpn(16'h005a, 16'h005a, 16'h005a);
		@(posedge clk_i) f_c <= 16'h028a;
		wb(1'b1, 8'h18, 32'h000a0258);
		wb(1'b1, 8'h08, 32'h00000011);
		wb(1'b1, 8'h1c, 32'h000a0258);
		wb(1'b1, 8'h0c, 32'h00000011);
		wait_ev(6, 30);
		chk("blocked", hit, 1'b0);
		setpn(16'h0064, 16'h0064, 16'h0064);
		wait_ev(13, 10);
		chk("above block", hit, 1'b1);
		wait_ev(6, 10);
		chk("of pickup", hit, 1'b1);
		setpn(16'h0063, 16'h0063, 16'h0063);
		wait_ev(8, 10);
		chk("of blocked drop", {hit, ev_seen[12], ev_seen[11], ev_seen[14]},
			4'hf);
		setpn(16'h0064, 16'h0064, 16'h0064);
		wait_ev(7, 150);
		chk("of delay", n inside {[90:111]}, 1'b1);
		chk("of open", {brk_open_o, alarm_o}, 2'b11);
		@(posedge clk_i) f_c <= 16'h0246;
		wait_ev(8, 30);
		chk("of holds", hit, 1'b0);
		@(posedge clk_i) f_c <= 16'h0245;
		wait_ev(8, 10);
		chk("of dropout", {hit, ev_seen[11]}, 2'b11);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_ov_trip();
		t_ov_phases();
		t_of();
		conclude();
	end
endmodule

// file: ovf_relay.sv
// over voltage and over frequency protective relay with wishbone registers
// Function
// - compare each phase voltage with pickup relative to nominal_unit_voltage.
// - ov enters pickup when phases above pickup reach the configured count.
// - pickup held for the full delay enters operate, issuing breaker or alarm.
// - ov drops out when voltage falls below 97% of the threshold.
// - wye uses phase-neutral, open delta uses line-line rms voltage.
// - ov pickup 105..125 % in 1 % steps, per trip and alarm.
// - ov delay 0.5..600 s in 0.5 s steps.
// - phase selector picks any one, any two or all three phases.
// - operate action selects open without lockout or trip with lockout.
// - each instance has its own enable; disabled never picks up.
// - of picks up when phase a frequency exceeds its pickup.
// - of drops out when frequency falls below 97% of the threshold.
// - blocking enabled and voltage under blocking level suppresses of pickup.
// - of in pickup leaves pickup and clears timer when voltage blocks.
// - of pickup 50..70 Hz in 0.1 Hz steps, per trip and alarm.
// - of delay 0.1..600 s in 0.1 s steps.
// - blocking level fixed at 10 % of nominal voltage.
// - of operate time within 0.1 s of the programmed delay.
// - ov logs pickup, operate and dropout events per instance.
// - of also logs voltage below and above blocking level events.
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ovf_relay
	import ovf_relay_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [15:0] van_i,
	input wire logic [15:0] vbn_i,
	input wire logic [15:0] vcn_i,
	input wire logic [15:0] vab_i,
	input wire logic [15:0] vbc_i,
	input wire logic [15:0] vca_i,
	input wire logic [15:0] freq_a_i,
	output logic brk_open_o,
	output logic brk_trip_o,
	output logic lockout_o,
	output logic alarm_o,
	output logic [15:0] event_o
);

	relay_regs_t q, d;
	logic [2:0][15:0] volt;
	logic [3:0] hi, keep, blocked;
	logic low_now, tick;

	////////////////////////////////////////////////////////////////////////
	// measurement compare

	assign volt[0] = q.delta ? vab_i : van_i;
	assign volt[1] = q.delta ? vbc_i : vbn_i;
	assign volt[2] = q.delta ? vca_i : vcn_i;
	// blocking needs all three phases under the level
	assign low_now = (volt[0] < BLOCK_LEVEL) && (volt[1] < BLOCK_LEVEL)
		&& (volt[2] < BLOCK_LEVEL);
	assign tick = (q.pre == 22'(TICK_CYCLES - 1));

	genvar gi;
	generate
		for (gi = 0; gi < NUM_INST; gi++) begin : g_cmp
			logic [23:0] pk;
			logic [1:0] n_hi, n_keep, req;
			assign pk = {14'h0000, q.set[gi][SET_PK_LO +: 10]};
			assign req = q.ctl[gi][CTL_REQ_LO +: 2];
			if (gi < OF_TRIP) begin : g_ov
				logic [2:0] ph_hi, ph_keep;
				for (genvar p = 0; p < 3; p++) begin : g_ph
					// pickup percent * 10 gives 0.1 % units
					assign ph_hi[p] = {8'h00, volt[p]} > pk * VOLT_SCALE;
					assign ph_keep[p] = {8'h00, volt[p]} * VOLT_SCALE
						>= pk * DROP_PCT;
				end
				assign n_hi = 2'(ph_hi[0]) + 2'(ph_hi[1]) + 2'(ph_hi[2]);
				assign n_keep = 2'(ph_keep[0]) + 2'(ph_keep[1])
					+ 2'(ph_keep[2]);
				assign hi[gi] = n_hi >= req;
				assign keep[gi] = n_keep >= req;
				assign blocked[gi] = 1'b0;
			end else begin : g_of
				assign n_hi = 2'b00;
				assign n_keep = 2'b00;
				assign hi[gi] = {8'h00, freq_a_i} > pk;
				assign keep[gi] = {8'h00, freq_a_i} * FULL_PCT
					>= pk * DROP_PCT;
				assign blocked[gi] = q.ctl[gi][CTL_BLK] && low_now;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// register write helpers

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// out of range settings are clamped rather than rejected
	function automatic logic [31:0] clamp_set(input logic [31:0] v,
		input logic is_of);
		logic [9:0] pk;
		logic [12:0] dl;
		logic [9:0] pmin;
		logic [9:0] pmax;
		logic [12:0] dmax;
		pk = v[SET_PK_LO +: 10];
		dl = v[SET_DL_LO +: 13];
		pmin = is_of ? OF_PK_MIN : OV_PK_MIN;
		pmax = is_of ? OF_PK_MAX : OV_PK_MAX;
		dmax = is_of ? OF_DL_MAX : OV_DL_MAX;
		if (pk < pmin) begin
			pk = pmin;
		end else if (pk > pmax) begin
			pk = pmax;
		end
		if (dl < DL_MIN) begin
			dl = DL_MIN;
		end else if (dl > dmax) begin
			dl = dmax;
		end
		return {3'h0, dl, 6'h00, pk};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [5:0] idx;
		logic wr;
		logic [31:0] w;
		logic [31:0] rd;
		logic [15:0] dly;
		logic [15:0] clr;
		logic unlock;
		idx = adr_i[7:2];
		wr = cyc_i && stb_i && we_i && q.ack;
		w = 32'h0000_0000;
		rd = 32'h0000_0000;
		dly = 16'h0000;
		clr = 16'h0000;
		unlock = 1'b0;
		d = q;
		d.ev = 16'h0000;
		d.low = low_now;
		d.pre = tick ? 22'h000000 : q.pre + 22'h000001;

		// bus slave: data sampled on request, write lands on the ack edge
		d.ack = cyc_i && stb_i && !q.ack;
		if (idx < IDX_SET0) begin
			rd = {24'h000000, q.ctl[idx[1:0]]};
			w = merge(rd, dat_i, sel_i);
			if (wr) begin
				d.ctl[idx[1:0]] = w[7:0] & CTL_MASK;
				if (w[CTL_REQ_LO +: 2] == 2'b00) begin
					d.ctl[idx[1:0]][CTL_REQ_LO] = 1'b1;
				end
			end
		end else if (idx < IDX_GCTL) begin
			rd = q.set[idx[1:0]];
			if (wr) begin
				d.set[idx[1:0]] = clamp_set(merge(rd, dat_i, sel_i),
					idx[1]);
			end
		end else if (idx == IDX_GCTL) begin
			rd = {31'h0, q.delta};
			w = merge(rd, dat_i, sel_i);
			if (wr) begin
				d.delta = w[0];
			end
		end else if (idx == IDX_STAT) begin
			rd = {21'h0, q.delta, q.low, q.lock, q.st};
		end else if (idx == IDX_EVT) begin
			rd = {16'h0000, q.evt};
			w = merge(32'h0, dat_i, sel_i);
			if (wr) begin
				clr = w[15:0];
			end
		end else if (idx == IDX_CMD) begin
			w = merge(32'h0, dat_i, sel_i);
			unlock = wr && w[0];
		end
		if (cyc_i && stb_i && !q.ack) begin
			d.dat = rd;
		end

		// relay instances
		for (int i = 0; i < NUM_INST; i++) begin
			dly = q.set[i][SET_DL_LO +: 13]
				* ((i < OF_TRIP) ? OV_STEP : OF_STEP);
			if (!q.ctl[i][CTL_EN]) begin
				d.st[i] = ST_IDLE;
				d.tmr[i] = 16'h0000;
			end else begin
				case (q.st[i])
					ST_IDLE: begin
						d.tmr[i] = 16'h0000;
						if (hi[i] && !blocked[i]) begin
							d.st[i] = ST_PICKUP;
							d.ev[EV_PER_INST*i + EV_PICK] = 1'b1;
						end
					end
					ST_PICKUP: begin
						if (blocked[i] || !keep[i]) begin
							d.st[i] = ST_IDLE;
							d.tmr[i] = 16'h0000;
							d.ev[EV_PER_INST*i + EV_DROP] = 1'b1;
						end else if (tick) begin
							// free tick base: error stays under one tick
							d.tmr[i] = q.tmr[i] + 16'h0001;
							if (q.tmr[i] + 16'h0001 >= dly) begin
								d.st[i] = ST_OPERATE;
								d.ev[EV_PER_INST*i + EV_OPER] = 1'b1;
								if ((i % 2 == 0) && q.ctl[i][CTL_TRIP]) begin
									d.lock = 1'b1;
								end
							end
						end
					end
					ST_OPERATE: begin
						if (blocked[i] || !keep[i]) begin
							d.st[i] = ST_IDLE;
							d.tmr[i] = 16'h0000;
							d.ev[EV_PER_INST*i + EV_DROP] = 1'b1;
						end
					end
					default: begin
						d.st[i] = ST_IDLE;
					end
				endcase
			end
			// blocking level crossings, only while blocking is armed
			if (i >= OF_TRIP && q.ctl[i][CTL_EN] && q.ctl[i][CTL_BLK]) begin
				if (low_now && !q.low) begin
					d.ev[EV_BLK_LO + 2*(i-OF_TRIP)] = 1'b1;
				end else if (!low_now && q.low) begin
					d.ev[EV_BLK_LO + 2*(i-OF_TRIP) + 1] = 1'b1;
				end
			end
		end

		// a new event wins over a clear in the same cycle
		d.evt = (q.evt & ~clr) | d.ev;
		if (unlock && !(d.lock && !q.lock)) begin
			d.lock = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.ctl <= {NUM_INST{CTL_RST}};
			q.set[0] <= {3'h0, DL_MIN, 6'h00, OV_PK_MIN};
			q.set[1] <= {3'h0, DL_MIN, 6'h00, OV_PK_MIN};
			q.set[2] <= {3'h0, DL_MIN, 6'h00, OF_PK_MIN};
			q.set[3] <= {3'h0, DL_MIN, 6'h00, OF_PK_MIN};
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign ack_o = q.ack;
	assign dat_o = q.dat;
	assign event_o = q.ev;
	assign lockout_o = q.lock;
	assign brk_open_o = (q.st[OV_TRIP] == ST_OPERATE && !q.ctl[0][CTL_TRIP])
		|| (q.st[OF_TRIP] == ST_OPERATE && !q.ctl[2][CTL_TRIP]);
	assign brk_trip_o = (q.st[OV_TRIP] == ST_OPERATE && q.ctl[0][CTL_TRIP])
		|| (q.st[OF_TRIP] == ST_OPERATE && q.ctl[2][CTL_TRIP]);
	assign alarm_o = (q.st[1] == ST_OPERATE) || (q.st[3] == ST_OPERATE);

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_ov_pick;
		@(posedge clk_i) disable iff (rst_i)
		(q.st[0] == ST_IDLE && q.ctl[0][CTL_EN] && hi[0])
			|=> (q.st[0] == ST_PICKUP && event_o[0]);
	endproperty
	a_ov_pick: assert property (p_ov_pick)
		else $error("ov trip missed pickup");

	property p_disabled;
		@(posedge clk_i) disable iff (rst_i)
		!q.ctl[1][CTL_EN] |=> (q.st[1] == ST_IDLE && !event_o[3]);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled instance active");

	property p_ov_drop;
		@(posedge clk_i) disable iff (rst_i)
		(q.ctl[0][CTL_EN] && q.st[0] != ST_IDLE && !keep[0])
			|=> (q.st[0] == ST_IDLE && event_o[2] && q.tmr[0] == 16'h0000);
	endproperty
	a_ov_drop: assert property (p_ov_drop)
		else $error("ov dropout missed");

	property p_of_pick;
		@(posedge clk_i) disable iff (rst_i)
		(q.st[2] == ST_IDLE && q.ctl[2][CTL_EN] && hi[2] && !blocked[2])
			|=> q.st[2] == ST_PICKUP;
	endproperty
	a_of_pick: assert property (p_of_pick)
		else $error("of trip missed pickup");

	property p_block;
		@(posedge clk_i) disable iff (rst_i)
		blocked[3] |=> (q.st[3] == ST_IDLE && q.tmr[3] == 16'h0000);
	endproperty
	a_block: assert property (p_block)
		else $error("blocked of still in pickup");

	property p_of_drop;
		@(posedge clk_i) disable iff (rst_i)
		(q.ctl[3][CTL_EN] && q.st[3] != ST_IDLE && !keep[3])
			|=> event_o[11];
	endproperty
	a_of_drop: assert property (p_of_drop)
		else $error("of dropout event missed");

	property p_lock;
		@(posedge clk_i) disable iff (rst_i)
		($rose(q.st[0] == ST_OPERATE) && q.ctl[0][CTL_TRIP])
			|-> (lockout_o && brk_trip_o && !brk_open_o);
	endproperty
	a_lock: assert property (p_lock)
		else $error("trip without lockout");

	property p_timer;
		@(posedge clk_i) disable iff (rst_i)
		(q.st[1] == ST_PICKUP && q.ctl[1][CTL_EN] && keep[1] && tick)
			|=> (q.tmr[1] == $past(q.tmr[1]) + 16'h0001);
	endproperty
	a_timer: assert property (p_timer)
		else $error("delay timer did not advance");

	property p_sticky;
		@(posedge clk_i) disable iff (rst_i)
		event_o[4] |-> q.evt[4];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("event not recorded");

endmodule

// file: ovf_relay_pkg.sv
// constants, register map and types for the over voltage / frequency relay
package ovf_relay_pkg;

	// clock and delay time base
	localparam int CLK_KHZ = 40000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES_DEF = TICK_MS * CLK_KHZ;

	// instances: 0 ov trip, 1 ov alarm, 2 of trip, 3 of alarm
	localparam int NUM_INST = 4;
	localparam int OV_TRIP = 0;
	localparam int OF_TRIP = 2;

	// register word indexes (byte address = index * 4)
	localparam logic [5:0] IDX_CTL0 = 6'h00;
	localparam logic [5:0] IDX_SET0 = 6'h04;
	localparam logic [5:0] IDX_GCTL = 6'h08;
	localparam logic [5:0] IDX_STAT = 6'h09;
	localparam logic [5:0] IDX_EVT = 6'h0a;
	localparam logic [5:0] IDX_CMD = 6'h0b;

	// control register fields
	localparam int CTL_EN = 0;
	localparam int CTL_TRIP = 1;
	localparam int CTL_REQ_LO = 2;
	localparam int CTL_BLK = 4;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] CTL_MASK = 8'h1f;

	// setting register fields: pickup [9:0], delay steps [28:16]
	localparam int SET_PK_LO = 0;
	localparam int SET_DL_LO = 16;
	localparam logic [9:0] OV_PK_MIN = 10'h069;
	localparam logic [9:0] OV_PK_MAX = 10'h07d;
	localparam logic [9:0] OF_PK_MIN = 10'h1f4;
	localparam logic [9:0] OF_PK_MAX = 10'h2bc;
	localparam logic [12:0] OV_DL_MAX = 13'h04b0;
	localparam logic [12:0] OF_DL_MAX = 13'h1770;
	localparam logic [12:0] DL_MIN = 13'h0001;
	localparam logic [15:0] OV_STEP = 16'h0005;
	localparam logic [15:0] OF_STEP = 16'h0001;

	// voltages in 0.1 % of nominal_unit_voltage, frequency in 0.1 Hz
	localparam logic [23:0] VOLT_SCALE = 24'h00000a;
	localparam logic [23:0] DROP_PCT = 24'h000061;
	localparam logic [23:0] FULL_PCT = 24'h000064;
	localparam logic [15:0] BLOCK_LEVEL = 16'h0064;

	// event bit layout
	localparam int EV_PER_INST = 3;
	localparam int EV_PICK = 0;
	localparam int EV_OPER = 1;
	localparam int EV_DROP = 2;
	localparam int EV_BLK_LO = 12;

	// status fields
	localparam int STAT_LOCK = 8;
	localparam int STAT_LOW = 9;
	localparam int STAT_DELTA = 10;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PICKUP = 2'b01,
		ST_OPERATE = 2'b10
	} rly_state_t;

	typedef struct packed {
		rly_state_t [3:0] st;
		logic [3:0][15:0] tmr;
		logic [21:0] pre;
		logic [3:0][7:0] ctl;
		logic [3:0][31:0] set;
		logic delta;
		logic lock;
		logic low;
		logic [15:0] evt;
		logic [15:0] ev;
		logic ack;
		logic [31:0] dat;
	} relay_regs_t;

endpackage
